// file: core/sysopt_regs.sv
// Decided for this implementation: the register addresses and the strobed register port.
module sysopt_regs
  import sysopt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [SYSOPT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // reset cause from reset controller, same clock
  input wire logic [7:0] reset_cause,
  // processor side, same clock
  input wire logic stop_attempt,
  input wire logic illegal_op_reset_disable,
  // option outputs
  output logic watchdog_enable,
  output logic watchdog_long_timeout,
  output logic stop_allow,
  output logic wait_allow,
  output logic watchdog_restart,
  output logic stop_mode_grant,
  output logic wait_mode_grant,
  output logic illegal_stop_reset,
  // clock output pin
  output logic clkout_port_pin,
  output logic clkout_port_oe
);

  // option bits
  logic options_locked;
  logic next_options_locked;
  logic next_watchdog_enable;
  logic next_watchdog_long_timeout;
  logic next_stop_allow;
  logic next_wait_allow;

  // clock output control
  logic clkout_pin_enable;
  logic [SYSOPT_DIV_W-1:0] clkout_divide_select;

  // reset source status
  logic [7:0] reset_source_status;
  logic cause_captured;

  // read path
  logic [7:0] next_rdata;

  // divider link
  sysopt_clkdiv_if clkdiv_link ();

  // address decode
  wire sel_status = (reg_addr == SYSOPT_OFS_RESET_STATUS);
  wire sel_options = (reg_addr == SYSOPT_OFS_OPTIONS);
  wire sel_clkout = (reg_addr == SYSOPT_OFS_CLKOUT);
  wire sel_ident_high = (reg_addr == SYSOPT_OFS_IDENT_HIGH);
  wire sel_ident_low = (reg_addr == SYSOPT_OFS_IDENT_LOW);
  wire sel_block_status = (reg_addr == SYSOPT_OFS_BLOCK_STATUS);

  wire wr_status = reg_wr && sel_status;
  wire wr_options = reg_wr && sel_options;
  wire wr_clkout = reg_wr && sel_clkout;

  // write-once group accepts only while unlocked
  wire once_write_ok = wr_options && !options_locked;

  // incoming option values
  wire in_wdog_en = reg_wdata[SYSOPT_BIT_WDOG_EN];
  wire in_wdog_long = reg_wdata[SYSOPT_BIT_WDOG_LONG];
  wire in_stop_allow = reg_wdata[SYSOPT_BIT_STOP_ALLOW];
  wire in_wait_allow = reg_wdata[SYSOPT_BIT_WAIT_ALLOW];
  wire in_clkout_en = reg_wdata[SYSOPT_BIT_CLKOUT_EN];
  wire [SYSOPT_DIV_W-1:0] in_divide = reg_wdata[SYSOPT_DIV_LSB +: SYSOPT_DIV_W];

  // stop instruction qualifiers
  wire both_modes_off = !stop_allow && !wait_allow;
  wire stop_fault = stop_attempt && both_modes_off;
  wire stop_fault_resets = stop_fault && !illegal_op_reset_disable;
  wire stop_ok = stop_attempt && stop_allow;
  wire wait_ok = stop_attempt && !stop_allow && wait_allow;

  // divided clock running on the pin
  wire clkout_running = clkout_pin_enable && (clkout_divide_select != '0);

  // read values
  wire [7:0] rd_options = {
    watchdog_enable,
    watchdog_long_timeout,
    stop_allow,
    wait_allow,
    4'h0
  };
  wire [7:0] rd_clkout = {
    3'h0,
    clkout_pin_enable,
    1'b0,
    clkout_divide_select
  };
  wire [7:0] rd_ident_high = {4'h0, SYSOPT_PART_IDENT[11:8]};
  wire [7:0] rd_ident_low = SYSOPT_PART_IDENT[7:0];
  wire [7:0] rd_block_status = {
    5'h00,
    clkout_running,
    both_modes_off,
    options_locked
  };

  // next option values
  always_comb begin
    next_options_locked = options_locked;
    next_watchdog_enable = watchdog_enable;
    next_watchdog_long_timeout = watchdog_long_timeout;
    next_stop_allow = stop_allow;
    next_wait_allow = wait_allow;
    if (once_write_ok) begin
      next_options_locked = 1'b1;
      next_watchdog_enable = in_wdog_en;
      next_watchdog_long_timeout = in_wdog_long;
      next_stop_allow = in_stop_allow;
    end
    if (wr_options) begin
      next_wait_allow = in_wait_allow;
    end
  end

  // read multiplexer
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (1'b1)
        sel_status: next_rdata = reset_source_status;
        sel_options: next_rdata = rd_options;
        sel_clkout: next_rdata = rd_clkout;
        sel_ident_high: next_rdata = rd_ident_high;
        sel_ident_low: next_rdata = rd_ident_low;
        sel_block_status: next_rdata = rd_block_status;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // option registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      options_locked <= 1'b0;
      watchdog_enable <= SYSOPT_RST_WDOG_EN;
      watchdog_long_timeout <= SYSOPT_RST_WDOG_LONG;
      stop_allow <= SYSOPT_RST_STOP_ALLOW;
      wait_allow <= SYSOPT_RST_WAIT_ALLOW;
    end else begin
      options_locked <= next_options_locked;
      watchdog_enable <= next_watchdog_enable;
      watchdog_long_timeout <= next_watchdog_long_timeout;
      stop_allow <= next_stop_allow;
      wait_allow <= next_wait_allow;
    end
  end

  // clock output control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clkout_pin_enable <= SYSOPT_RST_CLKOUT_EN;
      clkout_divide_select <= SYSOPT_RST_DIV;
    end else if (wr_clkout) begin
      clkout_pin_enable <= in_clkout_en;
      clkout_divide_select <= in_divide;
    end
  end

  // pin drive follows the enable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clkout_port_oe <= 1'b0;
    end else begin
      clkout_port_oe <= clkout_pin_enable;
    end
  end

  // reset cause caught once after release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_source_status <= SYSOPT_RST_RESET_STATUS;
      cause_captured <= 1'b0;
    end else if (!cause_captured) begin
      reset_source_status <= {reset_cause[7:1], 1'b0};
      cause_captured <= 1'b1;
    end
  end

  // watchdog restart on status write, contents kept
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= wr_status;
    end
  end

  // stop instruction outcome
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stop_mode_grant <= 1'b0;
      wait_mode_grant <= 1'b0;
      illegal_stop_reset <= 1'b0;
    end else begin
      stop_mode_grant <= stop_ok;
      wait_mode_grant <= wait_ok;
      illegal_stop_reset <= stop_fault_resets;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // divider driven from the control register
  assign clkdiv_link.enable = clkout_pin_enable;
  assign clkdiv_link.divide = clkout_divide_select;
  assign clkout_port_pin = clkdiv_link.clk_out;

  sysopt_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .port(clkdiv_link.div)
  );

endmodule

// file: core/sysopt_pkg.sv
package sysopt_pkg;

  typedef logic [7:0] sysopt_byte_t;

  localparam int SYSOPT_ADDR_W = 8;
  localparam int SYSOPT_DIV_W = 3;

  localparam logic [7:0] SYSOPT_OFS_RESET_STATUS = 8'h00;
  localparam logic [7:0] SYSOPT_OFS_OPTIONS = 8'h01;
  localparam logic [7:0] SYSOPT_OFS_CLKOUT = 8'h02;
  localparam logic [7:0] SYSOPT_OFS_IDENT_HIGH = 8'h03;
  localparam logic [7:0] SYSOPT_OFS_IDENT_LOW = 8'h04;
  localparam logic [7:0] SYSOPT_OFS_BLOCK_STATUS = 8'h05;

  localparam int SYSOPT_BIT_WDOG_EN = 7;
  localparam int SYSOPT_BIT_WDOG_LONG = 6;
  localparam int SYSOPT_BIT_STOP_ALLOW = 5;
  localparam int SYSOPT_BIT_WAIT_ALLOW = 4;

  localparam int SYSOPT_BIT_CLKOUT_EN = 4;
  localparam int SYSOPT_DIV_LSB = 0;

  localparam int SYSOPT_BIT_STAT_LOCKED = 0;
  localparam int SYSOPT_BIT_STAT_STOP_FAULT = 1;
  localparam int SYSOPT_BIT_STAT_CLKOUT_RUN = 2;

  localparam logic SYSOPT_RST_WDOG_EN = 1'b1;
  localparam logic SYSOPT_RST_WDOG_LONG = 1'b1;
  localparam logic SYSOPT_RST_STOP_ALLOW = 1'b0;
  localparam logic SYSOPT_RST_WAIT_ALLOW = 1'b1;
  localparam logic SYSOPT_RST_CLKOUT_EN = 1'b0;
  localparam logic [2:0] SYSOPT_RST_DIV = 3'h0;
  localparam logic [7:0] SYSOPT_RST_RESET_STATUS = 8'h00;

  // arbitrary identifier value
  localparam logic [11:0] SYSOPT_PART_IDENT = 12'h5A3;

endpackage

// file: core/sysopt_clkdiv_if.sv
interface sysopt_clkdiv_if;
  import sysopt_pkg::*;

  logic enable;
  logic [SYSOPT_DIV_W-1:0] divide;
  logic clk_out;

  modport ctl (
    output enable,
    output divide,
    input clk_out
  );

  modport div (
    input enable,
    input divide,
    output clk_out
  );
endinterface

// file: core/sysopt_clkdiv.sv
module sysopt_clkdiv
  import sysopt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  sysopt_clkdiv_if.div port
);

  logic [SYSOPT_DIV_W-1:0] half_count;
  logic out_level;
  logic [SYSOPT_DIV_W-1:0] prev_divide;

  wire div_zero = (port.divide == '0);
  wire running = port.enable && !div_zero;
  wire div_changed = (port.divide != prev_divide);
  wire half_done = (half_count == port.divide - 3'h1);

  // toggles every N bus cycles, period 2N
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      half_count <= '0;
      out_level <= 1'b0;
      prev_divide <= '0;
    end else begin
      prev_divide <= port.divide;
      if (!running || div_changed) begin
        half_count <= '0;
        out_level <= 1'b0;
      end else if (half_done) begin
        half_count <= '0;
        out_level <= !out_level;
      end else begin
        half_count <= half_count + 3'h1;
      end
    end
  end

  assign port.clk_out = out_level;

endmodule

// file: testbench/sysopt_regs_props.sv
module sysopt_regs_props
  import sysopt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [SYSOPT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic stop_attempt,
  input wire logic illegal_op_reset_disable,
  input wire logic watchdog_enable,
  input wire logic watchdog_long_timeout,
  input wire logic stop_allow,
  input wire logic wait_allow,
  input wire logic watchdog_restart,
  input wire logic illegal_stop_reset,
  input wire logic clkout_port_pin,
  input wire logic clkout_port_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic locked;
  logic [2:0] div;
  logic [3:0] hi_cnt;
  logic [3:0] quiet;
  wire opt_wr = reg_wr && reg_addr == SYSOPT_OFS_OPTIONS;
  wire clk_wr = reg_wr && reg_addr == SYSOPT_OFS_CLKOUT;
  wire [2:0] opt_once = {watchdog_enable, watchdog_long_timeout, stop_allow};

  // shadow of lock, divide, high run and quiet time since last divider write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      locked <= 1'b0;
      div <= 3'h0;
      hi_cnt <= 4'h0;
      quiet <= 4'h0;
    end else begin
      locked <= locked | opt_wr;
      div <= clk_wr ? reg_wdata[2:0] : div;
      hi_cnt <= clkout_port_pin ? hi_cnt + 4'h1 : 4'h0;
      quiet <= clk_wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ident_low_a: assert property (reg_rd && reg_addr == SYSOPT_OFS_IDENT_LOW
    |=> reg_rdata == SYSOPT_PART_IDENT[7:0]) else $error("ident low read wrong");
  ident_high_a: assert property (reg_rd && reg_addr == SYSOPT_OFS_IDENT_HIGH
    |=> reg_rdata[3:0] == SYSOPT_PART_IDENT[11:8]) else $error("ident high read wrong");
  opt_read_a: assert property (reg_rd && reg_addr == SYSOPT_OFS_OPTIONS
    |=> reg_rdata == {opt_once, wait_allow, 4'h0}) else $error("options read differs from outputs");
  first_write_a: assert property (opt_wr && !locked
    |=> opt_once == $past(reg_wdata[7:5])) else $error("first options write not taken");
  once_lock_a: assert property (opt_wr && locked |=> $stable(opt_once))
    else $error("write-once bits changed after lock");
  wait_any_a: assert property (opt_wr |=> wait_allow == $past(reg_wdata[4]))
    else $error("wait enable not taken");
  wdog_restart_a: assert property (reg_wr && reg_addr == SYSOPT_OFS_RESET_STATUS |=> watchdog_restart)
    else $error("no watchdog restart");
  illegal_stop_a: assert property (stop_attempt && !stop_allow && !wait_allow
    |=> illegal_stop_reset == !$past(illegal_op_reset_disable)) else $error("illegal stop reset wrong");
  div_zero_a: assert property (clk_wr && reg_wdata[2:0] == 3'h0
    |-> ##2 !clkout_port_pin [*4]) else $error("pin not low with zero divide");
  pin_gate_a: assert property (!clkout_port_oe |-> !clkout_port_pin)
    else $error("pin active while not driven");
  half_period_a: assert property ($fell(clkout_port_pin) && quiet == 4'hF
    |-> hi_cnt == {1'b0, div}) else $error("clock output half period wrong");
endmodule

// file: testbench/tb_sysopt_regs.sv
module tb_sysopt_regs
  import sysopt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [SYSOPT_ADDR_W-1:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stop_attempt = 1'b0;
  logic illegal_op_reset_disable = 1'b0;
  logic [7:0] reset_cause = 8'h87;
  logic [7:0] reg_rdata;
  logic watchdog_enable, watchdog_long_timeout, stop_allow, wait_allow, watchdog_restart;
  logic stop_mode_grant, wait_mode_grant, illegal_stop_reset, clkout_port_pin, clkout_port_oe;
  logic [7:0] rv;
  int bad_count = 0;
  int checks_done = 0;

  always #2.5 clk_sys = ~clk_sys;

  sysopt_regs dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reset_cause,
    .stop_attempt, .illegal_op_reset_disable, .watchdog_enable, .watchdog_long_timeout, .stop_allow,
    .wait_allow, .watchdog_restart, .stop_mode_grant, .wait_mode_grant, .illegal_stop_reset,
    .clkout_port_pin, .clkout_port_oe);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic stop_try(input logic dis, input logic [2:0] exp);
    @(posedge clk_sys);
    stop_attempt <= 1'b1;
    illegal_op_reset_disable <= dis;
    @(posedge clk_sys);
    stop_attempt <= 1'b0;
    #1;
    chk("grants", {5'h0, stop_mode_grant, wait_mode_grant, illegal_stop_reset}, {5'h0, exp});
  endtask

  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (clkout_port_pin === lvl && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 40) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic measure(input int half);
    int hi;
    int lo;
    run_len(1'b1, lo); // skip a partial high run
    run_len(1'b0, lo);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    chk("high run", hi[7:0], half[7:0]);
    chk("low run", lo[7:0], half[7:0]);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  task automatic t_defaults();
    bus(0, SYSOPT_OFS_OPTIONS, 8'h00);
    chk("options reset", rv, 8'hD0);
    bus(0, SYSOPT_OFS_CLKOUT, 8'h00);
    chk("clkout reset", rv, 8'h00);
    bus(1, SYSOPT_OFS_IDENT_HIGH, 8'hFF);
    bus(1, SYSOPT_OFS_IDENT_LOW, 8'hFF);
    bus(0, SYSOPT_OFS_IDENT_HIGH, 8'h00);
    chk("ident high", rv, {4'h0, SYSOPT_PART_IDENT[11:8]});
    bus(0, SYSOPT_OFS_IDENT_LOW, 8'h00);
    chk("ident low", rv, SYSOPT_PART_IDENT[7:0]);
    bus(1, SYSOPT_OFS_RESET_STATUS, 8'hFF);
    chk("restart", {7'h0, watchdog_restart}, 8'h01);
    bus(0, SYSOPT_OFS_RESET_STATUS, 8'h00);
    chk("reset status", rv, reset_cause & 8'hFE);
  endtask

  task automatic t_write_once();
    bus(1, SYSOPT_OFS_OPTIONS, 8'h20);
    bus(0, SYSOPT_OFS_OPTIONS, 8'h00);
    chk("options first", rv, 8'h20);
    bus(1, SYSOPT_OFS_OPTIONS, 8'hD0);
    bus(0, SYSOPT_OFS_OPTIONS, 8'h00);
    chk("options locked", rv, 8'h30);
    stop_try(1'b0, 3'b100);
  endtask

  task automatic t_stop_modes();
    @(posedge clk_sys);
    do_reset();
    bus(0, SYSOPT_OFS_OPTIONS, 8'h00);
    chk("options relock", rv, 8'hD0);
    bus(1, SYSOPT_OFS_OPTIONS, 8'h00);
    stop_try(1'b0, 3'b001);
    stop_try(1'b1, 3'b000);
    bus(1, SYSOPT_OFS_OPTIONS, 8'h10);
    stop_try(1'b0, 3'b010);
  endtask

  task automatic t_clkout();
    bus(1, SYSOPT_OFS_CLKOUT, 8'hFF);
    bus(0, SYSOPT_OFS_CLKOUT, 8'h00);
    chk("clkout unused", rv, 8'h17);
    measure(7);
    bus(1, SYSOPT_OFS_CLKOUT, 8'h13);
    measure(3);
    chk("pin driven", {7'h0, clkout_port_oe}, 8'h01);
    bus(1, SYSOPT_OFS_CLKOUT, 8'h10);
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      #1;
      chk("zero divide", {7'h0, clkout_port_pin}, 8'h00);
    end
    bus(1, SYSOPT_OFS_CLKOUT, 8'h03);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("pin released", {6'h0, clkout_port_oe, clkout_port_pin}, 8'h00);
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_write_once();
    t_stop_modes();
    t_clkout();
    complete_run();
  end
endmodule

bind sysopt_regs sysopt_regs_props chk_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .stop_attempt, .illegal_op_reset_disable, .watchdog_enable, .watchdog_long_timeout,
  .stop_allow, .wait_allow, .watchdog_restart, .illegal_stop_reset, .clkout_port_pin, .clkout_port_oe);
